// [logic/mmul_regs.vh]
// constants for the 2x2 two-bit matrix multiplier
`ifndef MMUL_REGS_VH
`define MMUL_REGS_VH
`define MMUL_ELEM_W 2
`define MMUL_MAT_W 8
`define MMUL_E00_HI 7
`define MMUL_E01_HI 5
`define MMUL_E10_HI 3
`define MMUL_E11_HI 1
`define MMUL_RESULT_RST 8'h00
`define MMUL_BIDIR_OE 8'h00
`endif

// [logic/mmul_dot.v]
// two-term dot product of two-bit elements, kept modulo 4
`timescale 1ns/1ps
`include "mmul_regs.vh"
module mmul_dot (
  // operands
  input wire [1:0] a0_in,
  input wire [1:0] b0_in,
  input wire [1:0] a1_in,
  input wire [1:0] b1_in,
  // result
  output wire [1:0] sum_out
);
  wire [3:0] p0;
  wire [3:0] p1;
  wire [4:0] full;
  // operands widened first so the product keeps all four bits
  assign p0 = {2'b00, a0_in} * {2'b00, b0_in};
  assign p1 = {2'b00, a1_in} * {2'b00, b1_in};
  assign full = {1'b0, p0} + {1'b0, p1};
  // only two pins per element, upper bits dropped
  assign sum_out = full[1:0];
endmodule // mmul_dot

// [logic/mmul_top.v]
// 2x2 matrix multiplier with two-bit elements, pin level datapath
// What this block does
// - matrix A from dedicated inputs, row-major, element (0,0) in bits 7:6.
// - bidirectional pins kept as inputs, carry matrix B in same packing.
// - result C on output pins, row-major, element (0,0) in bits 7:6.
// - each C(i,j) is sum over k of A(i,k) times B(k,j), kept modulo 4.
`timescale 1ns/1ps
`include "mmul_regs.vh"
module mmul_top (
  // clock and reset
  input wire mclk_in,
  input wire rst_in,
  // matrix a pins
  input wire [7:0] mat_a_in,
  // matrix b bidirectional pins
  input wire [7:0] mat_b_in,
  output wire [7:0] mat_b_out,
  output wire [7:0] mat_b_oe_out,
  // result pins
  output reg [7:0] mat_c_out
);
  // synchroniser stages; only the second flop of each pair feeds logic
  reg [7:0] a_s1;
  reg [7:0] a_s2;
  reg [7:0] b_s1;
  reg [7:0] b_s2;
  // operand elements, taken from the second synchroniser flops
  wire [1:0] a00;
  wire [1:0] a01;
  wire [1:0] a10;
  wire [1:0] a11;
  wire [1:0] b00;
  wire [1:0] b01;
  wire [1:0] b10;
  wire [1:0] b11;
  // result elements, already kept to two bits
  wire [1:0] c00;
  wire [1:0] c01;
  wire [1:0] c10;
  wire [1:0] c11;
  wire [7:0] next_c;

  // element idx of a row-major packed matrix, idx 0 is (0,0)
  function [1:0] elem;
    input [7:0] m;
    input [1:0] idx;
    begin
      case (idx)
        2'd0: elem = m[`MMUL_E00_HI -: `MMUL_ELEM_W];
        2'd1: elem = m[`MMUL_E01_HI -: `MMUL_ELEM_W];
        2'd2: elem = m[`MMUL_E10_HI -: `MMUL_ELEM_W];
        2'd3: elem = m[`MMUL_E11_HI -: `MMUL_ELEM_W];
        default: elem = 2'b00;
      endcase
    end
  endfunction

  // never driven: pins stay inputs
  assign mat_b_out = 8'h00;
  assign mat_b_oe_out = `MMUL_BIDIR_OE;

  // switch pins settle at any time, two flops before use
  always @(posedge mclk_in) begin
    if (rst_in) begin
      a_s1 <= 8'h00;
      a_s2 <= 8'h00;
    end else begin
      a_s1 <= mat_a_in;
      a_s2 <= a_s1;
    end
  end

  // same treatment for the read-only bidirectional pins
  always @(posedge mclk_in) begin
    if (rst_in) begin
      b_s1 <= 8'h00;
      b_s2 <= 8'h00;
    end else begin
      b_s1 <= mat_b_in;
      b_s2 <= b_s1;
    end
  end

  // unpack both operands, element (0,0) in the top pair
  assign a00 = elem(a_s2, 2'd0);
  assign a01 = elem(a_s2, 2'd1);
  assign a10 = elem(a_s2, 2'd2);
  assign a11 = elem(a_s2, 2'd3);
  assign b00 = elem(b_s2, 2'd0);
  assign b01 = elem(b_s2, 2'd1);
  assign b10 = elem(b_s2, 2'd2);
  assign b11 = elem(b_s2, 2'd3);

  // row of a against column of b, a on the left: ab, not ba
  // c(0,0) = a(0,0) b(0,0) + a(0,1) b(1,0)
  mmul_dot u_c00 (
    .a0_in(a00),
    .b0_in(b00),
    .a1_in(a01),
    .b1_in(b10),
    .sum_out(c00)
  );

  // c(0,1) = a(0,0) b(0,1) + a(0,1) b(1,1)
  mmul_dot u_c01 (
    .a0_in(a00),
    .b0_in(b01),
    .a1_in(a01),
    .b1_in(b11),
    .sum_out(c01)
  );

  // c(1,0) = a(1,0) b(0,0) + a(1,1) b(1,0)
  mmul_dot u_c10 (
    .a0_in(a10),
    .b0_in(b00),
    .a1_in(a11),
    .b1_in(b10),
    .sum_out(c10)
  );

  // c(1,1) = a(1,0) b(0,1) + a(1,1) b(1,1)
  mmul_dot u_c11 (
    .a0_in(a10),
    .b0_in(b01),
    .a1_in(a11),
    .b1_in(b11),
    .sum_out(c11)
  );

  assign next_c = {c00, c01, c10, c11};

  // registered output trades a cycle for glitch-free pins
  always @(posedge mclk_in) begin
    if (rst_in) begin
      mat_c_out <= `MMUL_RESULT_RST;
    end else begin
      mat_c_out <= next_c;
    end
  end
endmodule // mmul_top

// [verification/mmul_chk_properties.sv]
// pin assertions for the multiplier
`timescale 1ns/1ps
module mmul_chk(input wire mclk_in, rst_in, input wire [7:0] mat_a_in, mat_b_in,
  mat_b_oe_out, mat_c_out);
  function [7:0] f(input [7:0] p, q);
    integer n;
    for (n = 0; n < 4; n = n + 1)
      f[7-2*n-:2] = p[7-4*(n/2)-:2]*q[7-2*(n%2)-:2]+p[5-4*(n/2)-:2]*q[3-2*(n%2)-:2];
  endfunction
  // pipeline holds reset zeros for three edges after release
  reg [1:0] since_rst;
  wire settled;
  always @(posedge mclk_in) begin
    if (rst_in) since_rst <= 2'd0;
    else if (since_rst != 2'd3) since_rst <= since_rst + 2'd1;
  end
  assign settled = (since_rst == 2'd3);
  default clocking @(posedge mclk_in); endclocking
  default disable iff (rst_in);
  chk_c_prod: assert property (settled |->
    mat_c_out == f($past(mat_a_in,3),$past(mat_b_in,3)))
    else $error("bad product");
  chk_c_wrap: assert property (settled && $past(mat_a_in&mat_b_in,3) == 8'hff |->
    mat_c_out == 8'haa)
    else $error("no wrap");
  chk_c_zero: assert property ($past(mat_a_in,3) == 8'h00 |-> mat_c_out == 8'h00)
    else $error("not zero");
  chk_c_hold: assert property (($stable(mat_a_in) && $stable(mat_b_in))[*4] |=>
    $stable(mat_c_out))
    else $error("output moved");
  chk_oe_low: assert property (mat_b_oe_out == 8'h00)
    else $error("pins driven");
  cover property (mat_c_out == 8'haa);
  cover property ($changed(mat_c_out));
  cover property (mat_b_in == 8'h10);
endmodule // mmul_chk

// [verification/mmul_pins.sv]
// switch model on the operand pins
`timescale 1ns/1ps
module mmul_pins(input wire [7:0] a_in, b_in, oe_in, drv_in, output wire [7:0] a_out, b_out);
  assign a_out = a_in;
  assign b_out = oe_in & drv_in | ~oe_in & b_in;
endmodule // mmul_pins

// [verification/mmul_top_tb_top.sv]
// bench for the multiplier
`timescale 1ns/1ps
module mmul_top_tb_top;
  reg mclk_in = 0, rst_in = 1;
  reg [7:0] a = 0, b = 0;
  wire [7:0] pa, pb, bo, oe, c;
  integer n_mismatch = 0, samples_checked = 0, k;
  mmul_top i_mmul_top(.mclk_in(mclk_in), .rst_in(rst_in), .mat_a_in(pa), .mat_b_in(pb),
    .mat_b_out(bo), .mat_b_oe_out(oe), .mat_c_out(c));
  mmul_pins i_mmul_pins(.a_in(a), .b_in(b), .oe_in(oe), .drv_in(bo), .a_out(pa), .b_out(pb));
  initial forever #2.5 mclk_in = ~mclk_in;
  function [7:0] mm(input [7:0] p, q);
    integer n;
    for (n = 0; n < 4; n = n + 1)
      mm[7-2*n-:2] = p[7-4*(n/2)-:2]*q[7-2*(n%2)-:2]+p[5-4*(n/2)-:2]*q[3-2*(n%2)-:2];
  endfunction
  task check(input [7:0] s, e);
    begin
      samples_checked = samples_checked + 1;
      if (s !== e) begin
        n_mismatch = n_mismatch + 1;
        $display("[ERR] %0t seen %h expected %h", $time, s, e);
      end
    end
  endtask
  task summarize;
    begin
      if (n_mismatch == 0 && samples_checked > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
    end
  endtask
  // latency is three edges, a fourth lets the result settle
  task run(input [7:0] p, q);
    begin
      @(negedge mclk_in);
      a = p;
      b = q;
      repeat (4) @(negedge mclk_in);
      check(c, mm(p, q));
      check(oe, 8'h00);
      check(bo, 8'h00);
    end
  endtask
  initial begin
    k = $urandom(32'h34c6990b);
    repeat (10) @(negedge mclk_in);
    rst_in = 0;
    run(8'hff, 8'hff);
    // mid-run reset with new operands: output clears, then recovers
    @(negedge mclk_in);
    a = 8'h6b;
    b = 8'hd2;
    rst_in = 1;
    repeat (3) @(negedge mclk_in);
    check(c, 8'h00);
    rst_in = 0;
    repeat (4) @(negedge mclk_in);
    check(c, mm(8'h6b, 8'hd2));
    run(8'h40, 8'h10);
    run(8'h00, 8'h5a);
    for (k = 0; k < 200; k = k + 1) run(8'($urandom), 8'($urandom));
    summarize;
  end
  initial begin
    #20000;
    n_mismatch = n_mismatch + 1;
    summarize;
  end
endmodule // mmul_top_tb_top
bind mmul_top mmul_chk i_mmul_chk(.mclk_in(mclk_in), .rst_in(rst_in), .mat_a_in(mat_a_in),
  .mat_b_in(mat_b_in), .mat_b_oe_out(mat_b_oe_out), .mat_c_out(mat_c_out));
